// File: src/tev_top.sv
/*
  tap event detector top: register port, threshold compare per axis,
  tap source flags, latch mode and first interrupt pin routing.
  assumes: samples, tick and event inputs come from logic on core_clk_i.
*/
// The plain strobed port was decided locally.
`timescale 1ns/100ps
module tev_top
  import tev_pkg::*;
#(
  parameter int SAMPLE_W = 8
)
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  // register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rd_data_o,
  // samples, x in the low slice
  input wire logic sample_tick_i,
  input wire logic [NUM_AXES*SAMPLE_W-1:0] accel_i,
  // other event sources
  input wire logic inertial1_evt_i,
  input wire logic inertial2_evt_i,
  input wire logic xyz_ready_i,
  input wire logic aux_ready_i,
  input wire logic fifo_level_i,
  input wire logic fifo_overflow_i,
  // interrupt pin
  output logic first_interrupt_pin_o
);
  tev_tap_if tap ();

  logic [RT_TAP_BIT:RT_OVR_BIT] routing_q;
  logic [CFG_W-1:0] axis_cfg_q;
  logic tap_latch_select_q;
  logic [THS_W-1:0] threshold_q;
  logic [THS_W-1:0] tap_max_duration_q;
  logic [CNT_W-1:0] tap_quiet_interval_q;
  logic [CNT_W-1:0] second_tap_interval_q;
  logic tap_event_flag_q;
  logic tap_sign_q;
  logic [NUM_AXES-1:0] tap_axes_q;
  logic tick_q;
  logic [NUM_AXES-1:0] over_q;
  logic [NUM_AXES-1:0] neg_q;
  logic [NUM_AXES-1:0] dbl_en;
  logic [NUM_AXES-1:0] sgl_en;
  logic double_tap_flag;
  logic single_tap_flag;
  logic source_rd;
  logic tap_irq;
  logic [RT_TAP_BIT:RT_OVR_BIT] sources;
  logic [DATA_W-1:0] source_val;

  // per axis enables and threshold compare
  genvar g;
  generate
    for (g = 0; g < NUM_AXES; g++)
    begin : g_axis
      logic signed [SAMPLE_W-1:0] smp;
      logic [SAMPLE_W-1:0] mag;
      assign dbl_en[g] = axis_cfg_q[2*g+1];
      assign sgl_en[g] = axis_cfg_q[2*g];
      assign smp = accel_i[g*SAMPLE_W +: SAMPLE_W];
      assign mag = smp[SAMPLE_W-1] ? SAMPLE_W'(-smp) : SAMPLE_W'(smp);

      // compare once per new sample
      always_ff @(posedge core_clk_i or negedge arst_n_i)
      begin
        if (!arst_n_i)
        begin
          over_q[g] <= 1'b0;
          neg_q[g] <= 1'b0;
        end
        else if (sample_tick_i)
        begin
          over_q[g] <= mag > SAMPLE_W'(threshold_q);
          neg_q[g] <= smp[SAMPLE_W-1];
        end
      end
    end
  endgenerate

  // tick registered in the same cycle as the compare, one cycle after the input tick
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      tick_q <= 1'b0;
    else
      tick_q <= sample_tick_i;
  end

  // engine connections
  assign tap.tick = tick_q;
  assign tap.over = over_q;
  assign tap.neg = neg_q;
  assign tap.dbl_en = dbl_en;
  assign tap.sgl_en = sgl_en;
  assign tap.limit = tap_max_duration_q;
  assign tap.latency = tap_quiet_interval_q;
  assign tap.window = second_tap_interval_q;

  tev_tap_engine u_engine (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .tap(tap.engine)
  );

  // writable registers
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      routing_q <= REG_RESET[RT_TAP_BIT:RT_OVR_BIT];
      axis_cfg_q <= REG_RESET[CFG_W-1:0];
      tap_latch_select_q <= 1'b0;
      threshold_q <= REG_RESET[THS_W-1:0];
      tap_max_duration_q <= REG_RESET[THS_W-1:0];
      tap_quiet_interval_q <= REG_RESET;
      second_tap_interval_q <= REG_RESET;
    end
    else if (wr_i)
    begin
      unique case (addr_i)
        ROUTING_ADDR:
          routing_q <= wr_data_i[RT_TAP_BIT:RT_OVR_BIT];
        AXIS_CFG_ADDR:
          axis_cfg_q <= wr_data_i[CFG_W-1:0];
        THRESH_ADDR:
        begin
          tap_latch_select_q <= wr_data_i[THS_LATCH_BIT];
          threshold_q <= wr_data_i[THS_W-1:0];
        end
        LIMIT_ADDR:
          tap_max_duration_q <= wr_data_i[THS_W-1:0];
        LATENCY_ADDR:
          tap_quiet_interval_q <= wr_data_i;
        WINDOW_ADDR:
          second_tap_interval_q <= wr_data_i;
        default:
          ;
      endcase
    end
  end

  assign source_rd = rd_i && addr_i == SOURCE_ADDR;

  // tap source: set wins over the read clear
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      tap_event_flag_q <= 1'b0;
    else if (tap.evt)
      tap_event_flag_q <= 1'b1;
    else if (source_rd)
      tap_event_flag_q <= 1'b0;
  end

  // axis and sign of the last event
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      tap_axes_q <= '0;
      tap_sign_q <= 1'b0;
    end
    else if (tap.evt)
    begin
      tap_axes_q <= tap.evt_axes;
      tap_sign_q <= tap.evt_neg;
    end
  end

  // detection enable summary
  assign double_tap_flag = |dbl_en;
  assign single_tap_flag = |(sgl_en & ~dbl_en);

  always_comb
  begin
    source_val = REG_RESET;
    source_val[SRC_IA_BIT] = tap_event_flag_q;
    source_val[SRC_DBL_BIT] = double_tap_flag;
    source_val[SRC_SGL_BIT] = single_tap_flag;
    source_val[SRC_SIGN_BIT] = tap_sign_q;
    source_val[SRC_AXES_LSB +: NUM_AXES] = tap_axes_q;
  end

  // read data stand one cycle, zero otherwise
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rd_data_o <= REG_RESET;
    else if (rd_i)
    begin
      unique case (addr_i)
        ROUTING_ADDR:
          rd_data_o <= {routing_q, 1'b0};
        AXIS_CFG_ADDR:
          rd_data_o <= {2'b00, axis_cfg_q};
        SOURCE_ADDR:
          rd_data_o <= source_val;
        THRESH_ADDR:
          rd_data_o <= {tap_latch_select_q, threshold_q};
        LIMIT_ADDR:
          rd_data_o <= {1'b0, tap_max_duration_q};
        LATENCY_ADDR:
          rd_data_o <= tap_quiet_interval_q;
        WINDOW_ADDR:
          rd_data_o <= second_tap_interval_q;
        default:
          rd_data_o <= REG_RESET;
      endcase
    end
    else
      rd_data_o <= REG_RESET;
  end

  // latched flag or latency-long hold
  assign tap_irq = tap_latch_select_q ? tap_event_flag_q : tap.hold;

  // routed sources onto the first pin
  always_comb
  begin
    sources = '0;
    sources[RT_TAP_BIT] = tap_irq;
    sources[RT_IA1_BIT] = inertial1_evt_i;
    sources[RT_IA2_BIT] = inertial2_evt_i;
    sources[RT_XYZ_BIT] = xyz_ready_i;
    sources[RT_AUX_BIT] = aux_ready_i;
    sources[RT_WTM_BIT] = fifo_level_i;
    sources[RT_OVR_BIT] = fifo_overflow_i;
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      first_interrupt_pin_o <= 1'b0;
    else
      first_interrupt_pin_o <= |(sources & routing_q);
  end

  // event sets the active flag next cycle
  flag_set_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    tap.evt |=> tap_event_flag_q)
    else $error("active flag not set by event");

  // source read clears the flag when no event races it
  read_clear_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (source_rd && !tap.evt) |=> !tap_event_flag_q)
    else $error("source read did not clear flag");

  // latched pin stays up until a source read
  latch_hold_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (tap_latch_select_q && tap_event_flag_q && !source_rd && routing_q[RT_TAP_BIT]
     && !(wr_i && (addr_i == THRESH_ADDR || addr_i == ROUTING_ADDR))) |=> ##1 first_interrupt_pin_o)
    else $error("latched interrupt dropped early");

  // pin silent with routing all off
  route_off_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (routing_q == '0) |=> !first_interrupt_pin_o)
    else $error("pin high with routing off");

  // overflow routed alone reaches the pin
  overflow_pin_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (fifo_overflow_i && routing_q[RT_OVR_BIT]) |=> first_interrupt_pin_o)
    else $error("overflow not on pin");

  // no event while all axes stay disabled
  no_enable_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (axis_cfg_q == '0 && $past(axis_cfg_q) == '0 && $past(axis_cfg_q, 2) == '0) |-> !tap.evt)
    else $error("event with all axes disabled");

  // read data only in the cycle after a read
  read_data_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    !$past(rd_i) |-> rd_data_o == REG_RESET)
    else $error("read data outside read cycle");

  // threshold written reads back with latch bit
  thresh_rb_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (wr_i && addr_i == THRESH_ADDR) ##1 (rd_i && addr_i == THRESH_ADDR && !wr_i)
      |=> rd_data_o == $past(wr_data_i, 2))
    else $error("threshold readback mismatch");

  // event axes land in the source register
  axes_store_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    tap.evt |=> tap_axes_q == $past(tap.evt_axes))
    else $error("tap axes not stored");

  // event sign lands in the source register
  sign_store_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    tap.evt |=> tap_sign_q == $past(tap.evt_neg))
    else $error("tap sign not stored");

  // unlatched pin follows the hold window
  unlatched_pin_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (!tap_latch_select_q && tap.hold && routing_q[RT_TAP_BIT]) |=> first_interrupt_pin_o)
    else $error("unlatched interrupt missing during hold");

  // source read returns the active flag
  flag_read_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (rd_i && addr_i == SOURCE_ADDR) |=> rd_data_o[SRC_IA_BIT] == $past(tap_event_flag_q))
    else $error("active flag not in read data");

  // axis enables take the written value
  cfg_write_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (wr_i && addr_i == AXIS_CFG_ADDR) |=> {2'b00, axis_cfg_q} == ($past(wr_data_i) & 8'h3F))
    else $error("axis enables not written");

  // routing enables take the written value
  route_write_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (wr_i && addr_i == ROUTING_ADDR) |=> {routing_q, 1'b0} == ($past(wr_data_i) & 8'hFE))
    else $error("routing enables not written");

  // fifo level routed reaches the pin
  level_pin_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (fifo_level_i && routing_q[RT_WTM_BIT]) |=> first_interrupt_pin_o)
    else $error("fifo level not on pin");

  // latency register takes the written value
  latency_write_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (wr_i && addr_i == LATENCY_ADDR) |=> tap_quiet_interval_q == $past(wr_data_i))
    else $error("latency not written");
endmodule

// File: src/tev_pkg.sv
/*
  tap event detector: register map, field positions, reset values and
  the recognition state encoding.
  assumes: byte-wide register port, three axes, samples on a tick.
*/
package tev_pkg;
  localparam int NUM_AXES = 3;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CNT_W = 8;

  // register offsets
  localparam logic [ADDR_W-1:0] ROUTING_ADDR = 8'h22;
  localparam logic [ADDR_W-1:0] AXIS_CFG_ADDR = 8'h38;
  localparam logic [ADDR_W-1:0] SOURCE_ADDR = 8'h39;
  localparam logic [ADDR_W-1:0] THRESH_ADDR = 8'h3A;
  localparam logic [ADDR_W-1:0] LIMIT_ADDR = 8'h3B;
  localparam logic [ADDR_W-1:0] LATENCY_ADDR = 8'h3C;
  localparam logic [ADDR_W-1:0] WINDOW_ADDR = 8'h3D;

  // reset values
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;

  // tap_source fields; axis bits z=2 y=1 x=0
  localparam int SRC_IA_BIT = 6;
  localparam int SRC_DBL_BIT = 5;
  localparam int SRC_SGL_BIT = 4;
  localparam int SRC_SIGN_BIT = 3;
  localparam int SRC_AXES_LSB = 0;

  // tap_threshold fields
  localparam int THS_LATCH_BIT = 7;
  localparam int THS_W = 7;

  // tap_axis_config: axis i double at 2i+1, single at 2i
  localparam int CFG_W = 6;

  // first_interrupt_pin_source_routing bits
  localparam int RT_TAP_BIT = 7;
  localparam int RT_IA1_BIT = 6;
  localparam int RT_IA2_BIT = 5;
  localparam int RT_XYZ_BIT = 4;
  localparam int RT_AUX_BIT = 3;
  localparam int RT_WTM_BIT = 2;
  localparam int RT_OVR_BIT = 1;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FIRST = 3'b001,
    ST_LATENCY = 3'b010,
    ST_WINDOW = 3'b011,
    ST_SECOND = 3'b100,
    ST_QUIET = 3'b101,
    ST_DRAIN = 3'b110
  } tev_state_type;
endpackage

// File: src/tev_tap_if.sv
/*
  carrier between the register side and the tap recognition engine.
  assumes: both ends on core_clk_i.
*/
`timescale 1ns/100ps
interface tev_tap_if;
  import tev_pkg::*;
  logic tick;
  logic [NUM_AXES-1:0] over;
  logic [NUM_AXES-1:0] neg;
  logic [NUM_AXES-1:0] dbl_en;
  logic [NUM_AXES-1:0] sgl_en;
  logic [THS_W-1:0] limit;
  logic [CNT_W-1:0] latency;
  logic [CNT_W-1:0] window;
  logic evt;
  logic evt_double;
  logic [NUM_AXES-1:0] evt_axes;
  logic evt_neg;
  logic hold;

  modport engine (
    input tick, over, neg, dbl_en, sgl_en, limit, latency, window,
    output evt, evt_double, evt_axes, evt_neg, hold
  );
  modport ctrl (
    output tick, over, neg, dbl_en, sgl_en, limit, latency, window,
    input evt, evt_double, evt_axes, evt_neg, hold
  );
endinterface

// File: src/tev_tap_engine.sv
/*
  tap recognition engine: single and double tap timing on sample ticks.
  assumes: over/neg/tick registered by the caller, one tick per sample.
*/
`timescale 1ns/100ps
module tev_tap_engine
  import tev_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  // register side
  tev_tap_if.engine tap
);
  tev_state_type state_q, state_d;
  logic [CNT_W-1:0] cnt_q;
  logic dbl_mode_q;
  logic [NUM_AXES-1:0] axes_q;
  logic neg_q;
  logic [NUM_AXES-1:0] live;
  logic any_live;
  logic any_en;
  logic fire;
  logic cnt_next_ge_lat;

  // only enabled axes take part
  assign live = tap.over & (tap.dbl_en | tap.sgl_en);
  assign any_live = |live;
  // a running procedure only counts while one of its axes stays enabled
  assign any_en = |(axes_q & (tap.dbl_en | tap.sgl_en));
  assign cnt_next_ge_lat = (cnt_q + CNT_ONE) >= tap.latency;

  // next state of recognition
  always_comb
  begin
    state_d = state_q;
    fire = 1'b0;
    if (tap.tick)
    begin
      unique case (state_q)
        ST_IDLE:
          if (any_live)
            state_d = ST_FIRST;
        ST_FIRST, ST_SECOND:
          if (!any_live)
          begin
            if (cnt_q < {1'b0, tap.limit} && any_en)
            begin
              if (state_q == ST_FIRST && dbl_mode_q)
                state_d = ST_LATENCY;
              else
              begin
                state_d = ST_QUIET;
                fire = 1'b1;
              end
            end
            else
              state_d = ST_IDLE;
          end
          else if ((cnt_q + CNT_ONE) >= {1'b0, tap.limit})
            state_d = ST_DRAIN;
        ST_LATENCY:
          if (cnt_next_ge_lat)
            state_d = any_live ? ST_SECOND : ST_WINDOW;
        ST_WINDOW:
          if (any_live)
            state_d = ST_SECOND;
          else if ((cnt_q + CNT_ONE) >= tap.window)
            state_d = ST_IDLE;
        ST_QUIET:
          if (cnt_next_ge_lat)
            state_d = any_live ? ST_DRAIN : ST_IDLE;
        ST_DRAIN:
          if (!any_live)
            state_d = ST_IDLE;
        default:
          state_d = ST_IDLE;
      endcase
    end
  end

  // state register
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  // tick counter, restarted at every state change
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      cnt_q <= CNT_ZERO;
    else if (state_d != state_q)
      cnt_q <= CNT_ZERO;
    else if (tap.tick && cnt_q != CNT_MAX)
      cnt_q <= cnt_q + CNT_ONE;
  end

  // capture axes and sign at the start of each procedure, mode at the start of the first
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      axes_q <= '0;
      neg_q <= 1'b0;
      dbl_mode_q <= 1'b0;
    end
    else if (tap.tick && (state_q == ST_IDLE || state_q == ST_LATENCY || state_q == ST_WINDOW)
             && state_d != state_q && any_live)
    begin
      axes_q <= live;
      neg_q <= |(live & tap.neg);
      if (state_q == ST_IDLE)
        dbl_mode_q <= |(live & tap.dbl_en);
    end
  end

  // event pulse and hold window
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      tap.evt <= 1'b0;
      tap.evt_double <= 1'b0;
      tap.evt_axes <= '0;
      tap.evt_neg <= 1'b0;
    end
    else
    begin
      tap.evt <= fire;
      if (fire)
      begin
        tap.evt_double <= dbl_mode_q;
        tap.evt_axes <= axes_q;
        tap.evt_neg <= neg_q;
      end
    end
  end

  assign tap.hold = (state_q == ST_QUIET);

  // a double event only after a latency phase
  dbl_path_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (fire && dbl_mode_q) |-> state_q == ST_SECOND)
    else $error("double tap without second procedure");

  // no event during the latency phase
  latency_quiet_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    state_q == ST_LATENCY |-> !fire)
    else $error("event during latency");
endmodule

// File: verification/tev_sensor_model.sv
/*
  sample source model: feeds the detector one three-axis sample per tick.
  assumes: called from one bench process; tick period in core clocks.
*/
`timescale 1ns/100ps
module tev_sensor_model
  import tev_pkg::*;
#(
  parameter int SAMPLE_W = 8,
  parameter int TICK_PERIOD = 8
)
(
  // clock
  input wire logic core_clk_i,
  // sample stream
  output logic sample_tick_o,
  output logic [NUM_AXES*SAMPLE_W-1:0] accel_o
);
  // idle state at time zero
  initial
  begin
    sample_tick_o = 1'b0;
    accel_o = '0;
  end

  // one sample; outside the tick the value lines carry the inverse
  task automatic sample(input logic [SAMPLE_W-1:0] x, input logic [SAMPLE_W-1:0] y,
                        input logic [SAMPLE_W-1:0] z);
    @(posedge core_clk_i);
    sample_tick_o <= 1'b1;
    accel_o <= {z, y, x};
    @(posedge core_clk_i);
    sample_tick_o <= 1'b0;
    accel_o <= ~{z, y, x};
    repeat (TICK_PERIOD - 2) @(posedge core_clk_i);
  endtask
endmodule

// File: verification/tev_top_tb.sv
/*
  testbench for the tap event detector: register port tasks, routing,
  single and double tap sequences with expected flags and pin levels.
  assumes: sensor model supplies samples; host role played here.
*/
`timescale 1ns/100ps
module tev_top_tb
  import tev_pkg::*;
;
  logic core_clk;
  logic arst_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wr_data;
  logic wr;
  logic rd;
  logic [DATA_W-1:0] rd_data;
  logic tick;
  logic [NUM_AXES*8-1:0] accel;
  logic [5:0] evt_src;
  logic pin;
  logic [DATA_W-1:0] r;
  logic [ADDR_W-1:0] addrs [7];
  logic [DATA_W-1:0] rb [7];
  int n_fail;
  int compares;

  // 100 MHz clock
  always #5 core_clk = ~core_clk;

  tev_top #(.SAMPLE_W(8)) i_dut (
    .core_clk_i(core_clk), .arst_n_i(arst_n), .addr_i(addr), .wr_data_i(wr_data),
    .wr_i(wr), .rd_i(rd), .rd_data_o(rd_data), .sample_tick_i(tick), .accel_i(accel),
    .inertial1_evt_i(evt_src[5]), .inertial2_evt_i(evt_src[4]), .xyz_ready_i(evt_src[3]),
    .aux_ready_i(evt_src[2]), .fifo_level_i(evt_src[1]), .fifo_overflow_i(evt_src[0]),
    .first_interrupt_pin_o(pin));

  tev_sensor_model #(.SAMPLE_W(8), .TICK_PERIOD(8)) i_sensor (
    .core_clk_i(core_clk), .sample_tick_o(tick), .accel_o(accel));

  task automatic results();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    addr <= a;
    wr_data <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask

  // read data stands in the cycle after the strobe
  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 d = rd_data;
  endtask

  task automatic cmp_reg(input string name, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cmp_pin(input string name, input logic exp);
    #1;
    compares++;
    if (pin !== exp)
    begin
      n_fail++;
      $display("Error %s expected %b seen %b", name, exp, pin);
    end
  endtask

  task automatic chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] m, input logic [DATA_W-1:0] e);
    rd_reg(a, r);
    cmp_reg($sformatf("reg %h", a), e, r & m);
  endtask

  // bounded wait for the pin level; exhaustion ends the run
  task automatic wait_pin(input logic exp, input int bound);
    int i;
    for (i = 0; i < bound; i++)
    begin
      @(posedge core_clk);
      #1;
      if (pin === exp)
        break;
    end
    if (i == bound)
    begin
      n_fail++;
      $display("Error pin wait expected %b seen %b", exp, pin);
      results();
    end
    cmp_pin("pin", exp);
  endtask

  task automatic q(input int n);
    repeat (n) i_sensor.sample(8'h00, 8'h00, 8'h00);
  endtask

  // main sequence
  initial
  begin
    core_clk = 1'b0;
    arst_n = 1'b0;
    addr = '0;
    wr_data = '0;
    wr = 1'b0;
    rd = 1'b0;
    evt_src = '0;
    n_fail = 0;
    compares = 0;
    addrs = '{ROUTING_ADDR, AXIS_CFG_ADDR, SOURCE_ADDR, THRESH_ADDR, LIMIT_ADDR, LATENCY_ADDR, WINDOW_ADDR};
    rb = '{8'hFE, 8'h3F, 8'h20, 8'hFF, 8'h7F, 8'hFF, 8'hFF};
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    // reset values, write all ones, read back, unmapped place
    for (int i = 0; i < 7; i++) chk(addrs[i], 8'hFF, 8'h00);
    for (int i = 0; i < 7; i++) wr_reg(addrs[i], 8'hFF);
    for (int i = 0; i < 7; i++) chk(addrs[i], 8'hFF, rb[i]);
    // write then read the threshold with no gap between the strobes
    @(posedge core_clk);
    addr <= THRESH_ADDR;
    wr_data <= 8'hA5;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    cmp_reg("threshold back to back", 8'hA5, rd_data);
    chk(8'h40, 8'hFF, 8'h00);
    for (int i = 0; i < 7; i++) wr_reg(addrs[i], 8'h00);
    // per-axis enable truth table seen in the source flags
    for (int a = 0; a < 3; a++)
      for (int m = 0; m < 4; m++)
      begin
        wr_reg(AXIS_CFG_ADDR, 8'(m << (2 * a)));
        chk(SOURCE_ADDR, 8'h30, m[1] ? 8'h20 : (m[0] ? 8'h10 : 8'h00));
      end
    // each non-tap source alone, routed and unrouted
    for (int b = 1; b < 7; b++)
    begin
      wr_reg(ROUTING_ADDR, 8'(1 << b));
      evt_src <= ~(6'h01 << (b - 1));
      repeat (3) @(posedge core_clk);
      cmp_pin("unrouted", 1'b0);
      @(posedge core_clk);
      evt_src <= 6'h01 << (b - 1);
      wait_pin(1'b1, 4);
      @(posedge core_clk);
      evt_src <= 6'h00;
      wait_pin(1'b0, 4);
    end
    // latched single tap on x, then read clear
    wr_reg(ROUTING_ADDR, 8'h80);
    wr_reg(AXIS_CFG_ADDR, 8'h01);
    wr_reg(THRESH_ADDR, 8'h90);
    wr_reg(LIMIT_ADDR, 8'h02);
    i_sensor.sample(8'h14, 8'h00, 8'h00);
    q(1);
    wait_pin(1'b1, 4);
    q(3);
    cmp_pin("latched", 1'b1);
    chk(SOURCE_ADDR, 8'hFF, 8'h51);
    wait_pin(1'b0, 4);
    chk(SOURCE_ADDR, 8'h40, 8'h00);
    // value equal to threshold is no crossing
    i_sensor.sample(8'h10, 8'h00, 8'h00);
    q(2);
    chk(SOURCE_ADDR, 8'h40, 8'h00);
    // negative y: three ticks over is too long, two ticks is in time
    wr_reg(AXIS_CFG_ADDR, 8'h04);
    repeat (3) i_sensor.sample(8'h00, 8'hEC, 8'h00);
    q(3);
    chk(SOURCE_ADDR, 8'h40, 8'h00);
    repeat (2) i_sensor.sample(8'h00, 8'hEC, 8'h00);
    q(2);
    chk(SOURCE_ADDR, 8'hFF, 8'h5A);
    // no enable on z: no event
    wr_reg(AXIS_CFG_ADDR, 8'h00);
    i_sensor.sample(8'h00, 8'h00, 8'h14);
    q(2);
    chk(SOURCE_ADDR, 8'h40, 8'h00);
    cmp_pin("disabled", 1'b0);
    // unlatched double tap on z, second crossing inside the window
    wr_reg(AXIS_CFG_ADDR, 8'h20);
    wr_reg(THRESH_ADDR, 8'h10);
    wr_reg(LIMIT_ADDR, 8'h04);
    wr_reg(LATENCY_ADDR, 8'h02);
    wr_reg(WINDOW_ADDR, 8'h03);
    i_sensor.sample(8'h00, 8'h00, 8'h14);
    q(1);
    chk(SOURCE_ADDR, 8'h40, 8'h00);
    q(3);
    i_sensor.sample(8'h00, 8'h00, 8'h14);
    q(1);
    wait_pin(1'b1, 4);
    q(3);
    cmp_pin("unlatched", 1'b0);
    chk(SOURCE_ADDR, 8'hFF, 8'h64);
    // still over when the latency ends starts the second procedure
    i_sensor.sample(8'h00, 8'h00, 8'h14);
    q(1);
    repeat (3) i_sensor.sample(8'h00, 8'h00, 8'h14);
    q(1);
    chk(SOURCE_ADDR, 8'h40, 8'h40);
    q(3);
    // spacing beyond latency plus window is no double tap
    i_sensor.sample(8'h00, 8'h00, 8'h14);
    q(7);
    i_sensor.sample(8'h00, 8'h00, 8'h14);
    q(7);
    chk(SOURCE_ADDR, 8'h40, 8'h00);
    results();
  end
endmodule
